// file: verilog/dvm_params.svh
// constants for the pixel input capture and channel mapper
`ifndef DVM_PARAMS_SVH
`define DVM_PARAMS_SVH
`define DVM_OFF_FMT 32'h0000_0000
`define DVM_OFF_DSK 32'h0000_0004
`define DVM_OFF_STAT 32'h0000_0008
`define DVM_FMT_BUS 0
`define DVM_FMT_EDGE 1
`define DVM_FMT_CMS 2
`define DVM_DSK_EN 0
`define DVM_DSK_CODE 1
`define DVM_FMT_RST 3'h0
`define DVM_DSK_RST 4'h8
`define DVM_DSK_DEFAULT 3'h4
`define DVM_DSK_MID 4
`define DVM_CLK_PS 10000
`define DVM_STEP_PS 350
`define DVM_STEP_CYC ((`DVM_STEP_PS + `DVM_CLK_PS - 1) / `DVM_CLK_PS)
`define DVM_CTL_00 10'h354
`define DVM_CTL_01 10'h0AB
`define DVM_CTL_10 10'h154
`define DVM_CTL_11 10'h2AB
`endif

// file: verilog/dvm_pkg.sv
// types for the pixel input capture and channel mapper
package dvm_pkg;
  typedef struct packed {
    logic        valid;
    logic        hs;
    logic        vs;
    logic [2:0]  ctl;
    logic [23:0] data;
  } dvm_cap_t;

  typedef struct packed {
    logic       clk_p;
    logic       clk_n;
    dvm_cap_t   cap;
    logic       bus;
    logic       edge_sel;
    logic       cms;
    logic       dk_en;
    logic [2:0] dk_code;
    logic       msel;
    logic       hisw;
  } dvm_pins_t;

  typedef struct packed {
    logic [9:0]        q;
    logic signed [4:0] cnt;
  } dvm_enc_t;
endpackage : dvm_pkg

// file: verilog/dvm_top.sv
// pixel input capture, deskew and tmds channel mapping for a dvi transmitter
// How it works
// - encoder picks character by running disparity
// - active video: red, green, blue to lanes
// - blanking: syncs and control bits as characters
// - control bit 3 always sent as zero
// - bus width select picks 12 or 24
// - 12-bit mode captures on both edges
// - 24-bit mode edge chosen by edge select
// - 12-bit primary edge chosen by edge select
// - differential clock uses true/complement crossing
// - differential only low-swing, sense depends width
// - high swing forces single-ended clock
// - config from register or pins by select
// - deskew enable and 3-bit code exist
// - capture shifts by code minus four steps
// - deskew disabled uses fixed default offset
//
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`include "dvm_params.svh"
module dvm_top #(
  parameter int STEP_CYC = `DVM_STEP_CYC
) (
  input  wire logic              clk_i,                // 100 MHz system clock
  input  wire logic              reset_i,              // async reset, high
  input  wire logic              ce_i,                 // clock enable
  input  wire logic              hsel_i,               // ahb select
  input  wire logic [31:0]       haddr_i,              // ahb address
  input  wire logic [1:0]        htrans_i,             // ahb transfer type
  input  wire logic              hwrite_i,             // ahb write
  input  wire logic [2:0]        hsize_i,              // ahb size
  input  wire logic [31:0]       hwdata_i,             // ahb write data
  input  wire logic              hready_i,             // ahb ready in
  output logic [31:0]            hrdata_o,             // ahb read data
  output logic                   hreadyout_o,          // ahb ready out
  output logic                   hresp_o,              // ahb response
  input  wire logic              input_pixel_clock_p_i, // pixel clock true
  input  wire logic              input_pixel_clock_n_i, // pixel clock complement
  input  wire logic [23:0]       pixel_data_i,         // pixel data pins
  input  wire logic              pixel_valid_strobe_i, // data enable pin
  input  wire logic              hsync_i,              // horizontal sync
  input  wire logic              vsync_i,              // vertical sync
  input  wire logic [2:0]        aux_control_bits_i,   // control bits 3..1
  input  wire logic              bus_width_select_i,   // 0 12-bit, 1 24-bit
  input  wire logic              edge_select_i,        // 1 rising, 0 falling
  input  wire logic              clock_mode_select_i,  // clock mode pin
  input  wire logic              deskew_enable_i,      // deskew enable pin
  input  wire logic [2:0]        deskew_code_i,        // deskew code pin
  input  wire logic              mgmt_interface_select_i, // 1 registers
  input  wire logic              high_swing_i,         // 1 high-swing levels
  output logic [9:0]             serial_lane_blue_o,   // channel 0 character
  output logic [9:0]             serial_lane_green_o,  // channel 1 character
  output logic [9:0]             serial_lane_red_o,    // channel 2 character
  output logic                   char_valid_o          // new characters pulse
);
  import dvm_pkg::*;

  localparam int DLY  = `DVM_DSK_MID * STEP_CYC;
  localparam int HIST = 2 * DLY + 1;

  if (STEP_CYC < 1 || STEP_CYC > 16)
  begin : g_chk
    $error("dvm_top: STEP_CYC out of range");
  end

  typedef struct packed {
    dvm_pins_t                 s1;
    dvm_pins_t                 s2;
    logic                      lvl;
    logic [1:0]                warm;
    logic [DLY:0][1:0]         ehist;
    dvm_cap_t [HIST-1:0]       dhist;
    dvm_cap_t                  lo;
    logic                      pend;
    dvm_cap_t                  px;
    logic                      px_new;
    logic [2:0][9:0]           lane;
    logic signed [2:0][4:0]    disp;
    logic                      cv;
    logic                      a_wr;
    logic [1:0]                a_sel;
    logic [2:0]                fmt;
    logic [3:0]                dsk;
    logic [31:0]               rdata;
  } dvm_state_t;

  dvm_state_t st_reg;
  dvm_state_t st_next;
  dvm_pins_t  pins;
  logic       bw, edg, cms, dk_en, diff, lvl, rise, fall, prim, sec, take;
  logic [2:0] code;
  int         tap;
  dvm_cap_t   c;

  function automatic logic [1:0] dvm_dec(input logic [31:0] a);
    if (a == `DVM_OFF_FMT)
      return 2'h1;
    else if (a == `DVM_OFF_DSK)
      return 2'h2;
    else if (a == `DVM_OFF_STAT)
      return 2'h3;
    else
      return 2'h0;
  endfunction : dvm_dec

  function automatic logic [9:0] dvm_ctl_char(input logic [1:0] cc);
    case (cc)
      2'h0:    return `DVM_CTL_00;
      2'h1:    return `DVM_CTL_01;
      2'h2:    return `DVM_CTL_10;
      default: return `DVM_CTL_11;
    endcase
  endfunction : dvm_ctl_char

  // standard dc-balanced 8b/10b tmds data encoding
  function automatic dvm_enc_t dvm_enc(input logic [7:0] d, input logic signed [4:0] cnt);
    logic [8:0]        qm;
    logic [3:0]        n1;
    logic signed [4:0] diffq;
    logic              xn;
    dvm_enc_t          r;
    n1 = 4'h0;
    for (int i = 0; i < 8; i++)
      n1 = n1 + {3'h0, d[i]};
    xn = (n1 > 4'h4) || (n1 == 4'h4 && !d[0]);
    qm[0] = d[0];
    for (int i = 1; i < 8; i++)
      qm[i] = xn ? ~(qm[i-1] ^ d[i]) : (qm[i-1] ^ d[i]);
    qm[8] = ~xn;
    diffq = -5'sd8;
    for (int i = 0; i < 8; i++)
      diffq = diffq + (qm[i] ? 5'sd2 : 5'sd0);
    if (cnt == 5'sd0 || diffq == 5'sd0)
    begin
      r.q   = {~qm[8], qm[8], qm[8] ? qm[7:0] : ~qm[7:0]};
      r.cnt = qm[8] ? cnt + diffq : cnt - diffq;
    end
    else if ((cnt > 5'sd0 && diffq > 5'sd0) || (cnt < 5'sd0 && diffq < 5'sd0))
    begin
      r.q   = {1'b1, qm[8], ~qm[7:0]};
      r.cnt = cnt + (qm[8] ? 5'sd2 : 5'sd0) - diffq;
    end
    else
    begin
      r.q   = {1'b0, qm[8], qm[7:0]};
      r.cnt = cnt - (qm[8] ? 5'sd0 : 5'sd2) + diffq;
    end
    return r;
  endfunction : dvm_enc

  function automatic logic [7:0] dvm_dec_char(input logic [9:0] q);
    logic [7:0] d;
    logic [7:0] o;
    d = q[9] ? ~q[7:0] : q[7:0];
    o[0] = d[0];
    for (int i = 1; i < 8; i++)
      o[i] = q[8] ? (d[i] ^ d[i-1]) : ~(d[i] ^ d[i-1]);
    return o;
  endfunction : dvm_dec_char

  assign pins = '{clk_p: input_pixel_clock_p_i, clk_n: input_pixel_clock_n_i,
                  cap: '{valid: pixel_valid_strobe_i, hs: hsync_i, vs: vsync_i,
                         ctl: aux_control_bits_i, data: pixel_data_i},
                  bus: bus_width_select_i, edge_sel: edge_select_i,
                  cms: clock_mode_select_i, dk_en: deskew_enable_i,
                  dk_code: deskew_code_i, msel: mgmt_interface_select_i,
                  hisw: high_swing_i};

  always_comb
  begin
    st_next = st_reg;
    // every pixel and config pin passes two flops; only s2 is read by logic
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    bw    = st_reg.s2.msel ? st_reg.fmt[`DVM_FMT_BUS]  : st_reg.s2.bus;
    edg   = st_reg.s2.msel ? st_reg.fmt[`DVM_FMT_EDGE] : st_reg.s2.edge_sel;
    cms   = st_reg.s2.msel ? st_reg.fmt[`DVM_FMT_CMS]  : st_reg.s2.cms;
    dk_en = st_reg.s2.msel ? st_reg.dsk[`DVM_DSK_EN]   : st_reg.s2.dk_en;
    code  = st_reg.s2.msel ? st_reg.dsk[`DVM_DSK_CODE +: 3] : st_reg.s2.dk_code;
    if (!dk_en)
      code = `DVM_DSK_DEFAULT;
    diff = !st_reg.s2.hisw && (bw ? cms : !cms);
    // crossing of true and complement; hold level while both equal
    if (diff && st_reg.s2.clk_p == st_reg.s2.clk_n)
      lvl = st_reg.lvl;
    else
      lvl = st_reg.s2.clk_p;
    st_next.lvl = lvl;
    // no edges until the synchronisers hold real pin levels
    st_next.warm = st_reg.warm + {1'b0, st_reg.warm != 2'h3};
    rise = lvl & ~st_reg.lvl & (st_reg.warm == 2'h3);
    fall = ~lvl & st_reg.lvl & (st_reg.warm == 2'h3);
    // edges are delayed by the mid point so data may be taken early or late
    st_next.ehist = {st_reg.ehist[DLY-1:0], rise, fall};
    st_next.dhist = {st_reg.dhist[HIST-2:0], st_reg.s2.cap};
    tap  = (2 * `DVM_DSK_MID - int'(code)) * STEP_CYC;
    c    = st_reg.dhist[tap];
    prim = edg ? st_reg.ehist[DLY][1] : st_reg.ehist[DLY][0];
    sec  = edg ? st_reg.ehist[DLY][0] : st_reg.ehist[DLY][1];
    st_next.px_new = 1'b0;
    if (bw)
    begin
      if (prim)
      begin
        st_next.px     = c;
        st_next.px_new = 1'b1;
      end
    end
    else if (prim)
    begin
      st_next.lo   = c;
      st_next.pend = 1'b1;
    end
    else if (sec && st_reg.pend)
    begin
      st_next.px      = st_reg.lo;
      st_next.px.data = {c.data[11:0], st_reg.lo.data[11:0]};
      st_next.pend    = 1'b0;
      st_next.px_new  = 1'b1;
    end
    st_next.cv = st_reg.px_new;
    if (st_reg.px_new)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (st_reg.px.valid)
        begin
          {st_next.lane[i], st_next.disp[i]} =
            dvm_enc(st_reg.px.data[8*i +: 8], st_reg.disp[i]);
        end
        else
        begin
          st_next.disp[i] = 5'sd0;
          case (i)
            0:       st_next.lane[i] = dvm_ctl_char({st_reg.px.vs, st_reg.px.hs});
            1:       st_next.lane[i] = dvm_ctl_char({st_reg.px.ctl[0], 1'b0});
            default: st_next.lane[i] = dvm_ctl_char({1'b0, st_reg.px.ctl[1]});
          endcase
        end
      end
    end
    // zero-wait ahb slave; fmt and deskew reads use post-write values, status uses current ones
    take = hsel_i && htrans_i[1] && hready_i;
    if (st_reg.a_wr && st_reg.a_sel == 2'h1)
      st_next.fmt = hwdata_i[2:0];
    else if (st_reg.a_wr && st_reg.a_sel == 2'h2)
      st_next.dsk = hwdata_i[3:0];
    st_next.a_wr  = take && hwrite_i;
    st_next.a_sel = dvm_dec(haddr_i);
    if (take && !hwrite_i)
    begin
      if (dvm_dec(haddr_i) == 2'h1)
        st_next.rdata = {29'h0, st_next.fmt};
      else if (dvm_dec(haddr_i) == 2'h2)
        st_next.rdata = {28'h0, st_next.dsk};
      else if (dvm_dec(haddr_i) == 2'h3)
        st_next.rdata = {23'h0, st_reg.s2.hisw, st_reg.px.valid, code, dk_en, diff, edg, bw};
      else
        st_next.rdata = 32'h0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_reg     <= '0;
      st_reg.fmt <= `DVM_FMT_RST;
      st_reg.dsk <= `DVM_DSK_RST;
    end
    else if (ce_i)
      st_reg <= st_next;
  end

  assign hrdata_o            = st_reg.rdata;
  assign hreadyout_o         = 1'b1;
  assign hresp_o             = 1'b0;
  assign serial_lane_blue_o  = st_reg.lane[0];
  assign serial_lane_green_o = st_reg.lane[1];
  assign serial_lane_red_o   = st_reg.lane[2];
  assign char_valid_o        = st_reg.cv;

  default clocking cb @(posedge clk_i iff ce_i);
  endclocking
  default disable iff (reset_i);

  sequence s_blank;
    st_reg.px_new && !st_reg.px.valid;
  endsequence
  sequence s_active;
    st_reg.px_new && st_reg.px.valid;
  endsequence

  property p_disp_bound;
    char_valid_o |-> $signed(st_reg.disp[0]) <= 5'sd8 && $signed(st_reg.disp[0]) >= -5'sd8;
  endproperty
  property p_red_map;
    s_active ##1 1'b1 |-> dvm_dec_char(serial_lane_red_o) == $past(st_reg.px.data[23:16]);
  endproperty
  property p_blue_sync;
    s_blank ##1 1'b1 |-> serial_lane_blue_o == dvm_ctl_char({$past(st_reg.px.vs), $past(st_reg.px.hs)});
  endproperty
  property p_ctl3_zero;
    s_blank |=> serial_lane_red_o == `DVM_CTL_00 || serial_lane_red_o == `DVM_CTL_01;
  endproperty
  property p_half_join;
    st_reg.px_new && !$past(bw) |-> $past(st_reg.pend);
  endproperty
  property p_single_edge;
    st_reg.px_new && $past(bw) && $past(edg) |-> $past(st_reg.ehist[DLY][1]);
  endproperty
  property p_cfg_src;
    st_reg.s2.msel |-> bw == st_reg.fmt[`DVM_FMT_BUS] && edg == st_reg.fmt[`DVM_FMT_EDGE];
  endproperty
  property p_dsk_default;
    !dk_en |-> tap == DLY;
  endproperty
  property p_high_swing;
    st_reg.s2.hisw |-> !diff;
  endproperty

  a_disp_bound: assert property (p_disp_bound) else $error("disparity out of range");
  a_red_map: assert property (p_red_map) else $error("red lane does not carry red byte");
  a_blue_sync: assert property (p_blue_sync) else $error("blue lane lacks sync char");
  a_ctl3_zero: assert property (p_ctl3_zero) else $error("control bit 3 not zero");
  a_half_join: assert property (p_half_join) else $error("pixel without first half");
  a_single_edge: assert property (p_single_edge) else $error("24-bit capture off edge");
  a_cfg_src: assert property (p_cfg_src) else $error("config not from register");
  a_dsk_default: assert property (p_dsk_default) else $error("deskew default wrong");
  a_high_swing: assert property (p_high_swing) else $error("differential in high swing");
endmodule : dvm_top

// file: test/dvm_gfx_model.sv
// graphics controller model driving the parallel pixel bus
`timescale 1ns/100ps
module dvm_gfx_model (
  output logic        clk_p_o, // pixel clock true
  output logic        clk_n_o, // pixel clock complement
  output logic [23:0] data_o,  // pixel data
  output logic        de_o,    // data enable
  output logic        hs_o,    // horizontal sync
  output logic        vs_o,    // vertical sync
  output logic [2:0]  ctl_o    // control bits
);
  logic prim;
  logic half;
  logic diff;
  initial
  begin
    {prim, half, diff} = 3'b010;
    clk_p_o = 1'b1;
    {data_o, de_o, hs_o, vs_o, ctl_o} = '0;
  end
  // complement grounded when single-ended
  assign clk_n_o = diff ? ~clk_p_o : 1'b0;
  // clock moves only in send and when set_cfg parks it at ~e, so it stands between bursts
  task automatic set_cfg(input logic e, h, d);
    {prim, half, diff} = {e, h, d};
    clk_p_o = ~e;
  endtask : set_cfg
  task automatic send(input logic [23:0] p, input logic de, hs, vs, input logic [2:0] ctl);
    data_o = half ? {~p[23:12], p[11:0]} : p;
    {de_o, hs_o, vs_o, ctl_o} = {de, hs, vs, ctl};
    #40 clk_p_o = prim;
    // after the primary edge: second half on the low pins in 12-bit mode, else word no longer valid
    #40 data_o = half ? {p[11:0], p[23:12]} : ~p;
    #40 clk_p_o = ~prim;
    #40;
  endtask : send
endmodule : dvm_gfx_model

// file: test/dvm_top_tb.sv
// self-checking bench for the pixel capture and lane mapper
`timescale 1ns/100ps
`include "dvm_params.svh"
module dvm_top_tb;
  import dvm_pkg::*;
  logic        clk_i, reset_i, ce, hsel, hwrite, hready, hresp, cv;
  logic [1:0]  htrans;
  logic [2:0]  hsize, dkc, pctl;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic        bus, edge_sel, cms, deskew_enable, msel, hisw, pp, pn, pde, phs, pvs;
  logic [23:0] pdat;
  logic [9:0]  lb, lg, lr;
  logic [29:0] exp_q[$];
  int          cnt[3];
  int          fails, n_tests;
  logic [23:0] pix[5] = '{24'h000000, 24'hFFFFFF, 24'h123456, 24'hA5C30F, 24'h80FF01};

  dvm_top uut (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(hresp), .input_pixel_clock_p_i(pp), .input_pixel_clock_n_i(pn),
    .pixel_data_i(pdat), .pixel_valid_strobe_i(pde), .hsync_i(phs), .vsync_i(pvs),
    .aux_control_bits_i(pctl), .bus_width_select_i(bus), .edge_select_i(edge_sel),
    .clock_mode_select_i(cms), .deskew_enable_i(deskew_enable), .deskew_code_i(dkc),
    .mgmt_interface_select_i(msel), .high_swing_i(hisw), .serial_lane_blue_o(lb),
    .serial_lane_green_o(lg), .serial_lane_red_o(lr), .char_valid_o(cv));
  dvm_gfx_model gfx (.clk_p_o(pp), .clk_n_o(pn), .data_o(pdat), .de_o(pde),
    .hs_o(phs), .vs_o(pvs), .ctl_o(pctl));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string n, input logic [31:0] e, s);
    n_tests++;
    if (e !== s)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test

  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge clk_i);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, a};
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rv = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  function automatic logic [9:0] enc(input logic [7:0] d, inout int c);
    logic [8:0] m;
    logic [9:0] q;
    int         n1;
    logic       x;
    x = ($countones(d) > 4) || ($countones(d) == 4 && !d[0]);
    m[0] = d[0];
    for (int i = 1; i < 8; i++)
      m[i] = x ? ~(m[i-1] ^ d[i]) : (m[i-1] ^ d[i]);
    m[8] = ~x;
    n1 = $countones(m[7:0]);
    if (c == 0 || n1 == 4)
    begin
      q = {~m[8], m[8], m[8] ? m[7:0] : ~m[7:0]};
      c = c + (m[8] ? 2 * n1 - 8 : 8 - 2 * n1);
    end
    else if ((c > 0 && n1 > 4) || (c < 0 && n1 < 4))
    begin
      q = {1'b1, m[8], ~m[7:0]};
      c = c + 2 * int'(m[8]) + 8 - 2 * n1;
    end
    else
    begin
      q = {1'b0, m[8], m[7:0]};
      c = c - 2 * int'(!m[8]) + 2 * n1 - 8;
    end
    return q;
  endfunction : enc

  function automatic logic [9:0] ctlc(input logic [1:0] c);
    case (c)
      2'b00: return `DVM_CTL_00;
      2'b01: return `DVM_CTL_01;
      2'b10: return `DVM_CTL_10;
      default: return `DVM_CTL_11;
    endcase
  endfunction : ctlc

  task automatic px(input logic [23:0] p, input logic de, hs, vs, input logic [2:0] c);
    logic [29:0] e;
    if (de)
      e = {enc(p[23:16], cnt[2]), enc(p[15:8], cnt[1]), enc(p[7:0], cnt[0])};
    else
    begin
      cnt = '{0, 0, 0};
      e = {ctlc({1'b0, c[1]}), ctlc({c[0], 1'b0}), ctlc({vs, hs})};
    end
    exp_q.push_back(e);
    gfx.send(p, de, hs, vs, c);
  endtask : px

  // let settings cross the synchronisers, park the clock, then send a line
  task automatic burst(input logic e, h, d);
    repeat (8) @(negedge clk_i);
    gfx.set_cfg(e, h, d);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    for (int i = 0; i < 4; i++)
      px(24'h0, 1'b0, i[0], i[1], {1'b1, i[1], i[0]});
    foreach (pix[i])
      px(pix[i], 1'b1, 1'b0, 1'b0, 3'h0);
    repeat (40) @(posedge clk_i);
    chk("pending chars", 32'h0, exp_q.size());
  endtask : burst

  // settled lanes compared once per new character
  always @(negedge clk_i)
    if (cv === 1'b1)
      chk("lanes", {2'b00, exp_q.size() ? exp_q.pop_front() : 30'h0}, {2'b00, lr, lg, lb});

  initial
  begin
    #200000;
    fails++;
    finish_test();
  end

  initial
  begin
    reset_i = 1'b1;
    ce = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, hsize} = {4'h0, 64'h0, 3'b010};
    {bus, edge_sel, cms, deskew_enable, dkc, msel, hisw} = 9'h0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    ahb(0, `DVM_OFF_FMT, 0);
    chk("fmt reset", {29'h0, `DVM_FMT_RST}, rv);
    ahb(0, `DVM_OFF_DSK, 0);
    chk("deskew reset", {28'h0, `DVM_DSK_RST}, rv);
    ahb(1, 32'h0000_000C, 32'hFFFF_FFFF);
    ahb(0, 32'h0000_000C, 0);
    chk("unmapped", 32'h0, rv);
    for (int m = 0; m < 4; m++)
    begin
      {bus, edge_sel} <= m[1:0];
      burst(m[0], !m[1], !m[1]);
    end
    {bus, edge_sel, msel} <= 3'b001;
    ahb(1, `DVM_OFF_FMT, 32'h7);
    burst(1'b1, 1'b0, 1'b1);
    ahb(0, `DVM_OFF_STAT, 0);
    chk("status diff 24", 32'h007, rv & 32'h107);
    hisw <= 1'b1;
    burst(1'b1, 1'b0, 1'b0);
    ahb(0, `DVM_OFF_STAT, 0);
    chk("status high swing", 32'h100, rv & 32'h104);
    hisw <= 1'b0;
    ahb(1, `DVM_OFF_FMT, 32'h2);
    burst(1'b1, 1'b1, 1'b1);
    ahb(0, `DVM_OFF_STAT, 0);
    chk("status diff 12", 32'h006, rv & 32'h107);
    ahb(1, `DVM_OFF_DSK, 32'hF);
    ahb(0, `DVM_OFF_STAT, 0);
    chk("late code", 32'h78, rv & 32'h78);
    burst(1'b1, 1'b1, 1'b1);
    ahb(1, `DVM_OFF_DSK, 32'h3);
    ahb(0, `DVM_OFF_STAT, 0);
    chk("early code", 32'h18, rv & 32'h78);
    burst(1'b1, 1'b1, 1'b1);
    ahb(1, `DVM_OFF_DSK, 32'hE);
    ahb(0, `DVM_OFF_DSK, 0);
    chk("deskew reg", 32'hE, rv);
    ahb(0, `DVM_OFF_STAT, 0);
    chk("default code", 32'h40, rv & 32'h78);
    ce <= 1'b0;
    ahb(1, `DVM_OFF_DSK, 32'h5);
    ce <= 1'b1;
    ahb(0, `DVM_OFF_DSK, 0);
    chk("frozen deskew", 32'hE, rv);
    burst(1'b1, 1'b1, 1'b1);
    finish_test();
  end
endmodule : dvm_top_tb
